// ==== common/rlc_defs.svh ====
`ifndef RLC_DEFS_SVH
`define RLC_DEFS_SVH

// opcode shared by the immediate logical and and the immediate repeat form
`define RLC_OPC_IMM 8'h41
// direct register form, count comes from a general register
`define RLC_OPC_REG 8'h40
// destination byte that names the repeat counter
`define RLC_DEST_CNT 8'h04

// variant decode byte layout
`define RLC_VAR_TOP_HI 7
`define RLC_VAR_TOP_LO 6
`define RLC_VAR_INT_BIT 5
`define RLC_VAR_COND_BIT 4
`define RLC_VAR_SEL_HI 3
`define RLC_VAR_SEL_LO 0

// register byte offsets on the bus
`define RLC_OFS_CNT 8'h04
`define RLC_OFS_STAT 8'h08
`define RLC_OFS_CTRL 8'h0C
`define RLC_WORD_LO 2

// control register reset: repeat decoding enabled
`define RLC_CTRL_RST 1'b1
`define RLC_CTRL_EN_BIT 0

// counter step and terminal value
`define RLC_CNT_ONE 16'h0001
`define RLC_CNT_ZERO 16'h0000

`endif

// ==== common/rlc_pkg.sv ====
package rlc_pkg;

  // status flags produced by each executed instruction
  typedef struct packed {
    logic st;
    logic vt;
    logic v;
    logic c;
    logic n;
    logic z;
  } rlc_flags_t;

  // one decoded instruction offered by the pipeline
  typedef struct packed {
    logic [7:0] opcode;
    logic [15:0] imm;
    logic [15:0] regv;
    logic [7:0] variant;
    logic [7:0] dest;
  } rlc_instr_t;

  // why the last loop ended
  typedef struct packed {
    logic by_int;
    logic by_cond;
    logic by_count;
  } rlc_exit_t;

  // loop sequencer states
  typedef enum logic {
    RLC_IDLE = 1'b0,
    RLC_LOOP = 1'b1
  } rlc_state_t;

endpackage

// ==== rtl/rlc_cond_eval.sv ====
`timescale 1ns/1ns
// exit test for conditional variants, pure combinational
module rlc_cond_eval
  import rlc_pkg::*;
(
  input wire logic [3:0] sel,
  input wire rlc_flags_t flags,
  output logic hit
);

  // true forms for selector 8..F, in selector order
  wire [7:0] base;
  // upper half of the selector tests the plain flag forms
  wire upper;

  // st, higher, le, carry, vt, v, lt, equal [RULE11]
  assign base = {flags.z,
                 flags.n,
                 flags.v,
                 flags.vt,
                 flags.c,
                 flags.n | flags.z,
                 flags.c & ~flags.z,
                 flags.st};
  assign upper = sel[3];

  // lower half is the negation of the matching upper entry [RULE10]
  always_comb begin
    hit = base[sel[2:0]] ^ ~upper;
  end

endmodule

// ==== rtl/rlc_top.sv ====
// Chosen here: the Wishbone register port.
`timescale 1ns/1ns
`include "rlc_defs.svh"
// Notes on behaviour
// RULE1 - repeat re-executes only the next instruction
// RULE2 - software never repeats jumps, calls or returns
// RULE3 - repeat shares and opcode, destination decides
// RULE4 - decode byte picks one of four variants
// RULE5 - encoding: opcode, count low first, decode, dest
// RULE6 - load count; decrement then zero test
// RULE7 - end at zero, continue with next instruction
// RULE8 - initial zero count gives 65536 executions
// RULE9 - conditional: stop on zero or condition
// RULE10 - selector 0..7: negated condition tests
// RULE11 - selector 8..F: plain condition tests
// RULE12 - uninterruptible loops block interrupts throughout
// RULE13 - interruptible loops allow interrupts between iterations
// RULE14 - after interrupt, loop is not resumed
// RULE15 - software re-issues repeat if counter nonzero
// RULE16 - count from immediate or general register
// RULE17 - sixteen bit counter, readable, writable, undefined
// RULE18 - exit condition uses flags of each execution
module rlc_top
  import rlc_pkg::*;
#(
  parameter int CNT_W = 16
)
(
  input wire logic CLK_SYS,
  input wire logic ARST_N,
  // classic wishbone slave
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  // decode stage of the pipeline
  input wire logic DEC_VALID,
  input wire rlc_instr_t DEC_INSTR,
  // execute stage feedback
  input wire logic EXEC_DONE,
  input wire rlc_flags_t EXEC_FLAGS,
  input wire logic INT_TAKEN,
  // steering back to fetch and interrupt logic
  output logic IS_REPEAT,
  output logic REPEAT_ACTIVE,
  output logic INT_INHIBIT,
  output logic LOOP_END
);

  // loop state and variant held for the running loop
  rlc_state_t state_q;
  rlc_state_t state_d;
  logic intr_q;
  logic intr_d;
  logic cond_q;
  logic cond_d;
  logic [3:0] sel_q;
  logic [3:0] sel_d;
  rlc_exit_t exit_q;
  rlc_exit_t exit_d;

  // counter has no reset value, software must not rely on it
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;

  // control register, bit 0 enables repeat decoding
  logic ctrl_en_q;
  logic ctrl_en_d;

  // registered outputs
  logic ack_q;
  logic [31:0] rdat_q;
  logic [31:0] rdat_d;
  logic is_rep_q;
  logic loop_end_q;
  // inhibit is its own flop so interrupt logic sees no decode glitch
  logic inhibit_q;

  // decode
  // opcode of either and form
  wire opc_imm;
  wire opc_reg;
  wire opc_hit;
  // destination names the counter
  wire dest_hit;
  // variant byte fields
  wire var_top_ok;
  wire var_int;
  wire var_cond;
  wire [3:0] var_sel;
  wire var_ok;
  // final decision and chosen count
  wire rep_go;
  wire [CNT_W-1:0] load_val;

  assign opc_imm = DEC_INSTR.opcode == `RLC_OPC_IMM;
  assign opc_reg = DEC_INSTR.opcode == `RLC_OPC_REG;
  assign opc_hit = opc_imm | opc_reg;
  // the destination, with a decode byte in range, tells repeat from and [RULE3]
  assign dest_hit = DEC_INSTR.dest == `RLC_DEST_CNT; // [RULE5]

  // upper two bits of the variant must be clear [RULE4]
  assign var_top_ok =
    DEC_INSTR.variant[`RLC_VAR_TOP_HI:`RLC_VAR_TOP_LO] == 2'h0;
  assign var_int = DEC_INSTR.variant[`RLC_VAR_INT_BIT];
  assign var_cond = DEC_INSTR.variant[`RLC_VAR_COND_BIT];
  assign var_sel =
    DEC_INSTR.variant[`RLC_VAR_SEL_HI:`RLC_VAR_SEL_LO];
  // unconditional forms carry a zero selector: 00H or 20H [RULE4]
  assign var_ok = var_top_ok & (var_cond | (var_sel == 4'h0));

  // a decode byte outside the four ranges stays a plain and
  assign rep_go = DEC_VALID & ctrl_en_q & opc_hit & dest_hit
                  & var_ok & (state_q == RLC_IDLE); // [RULE3]

  // immediate word or register contents [RULE16]
  assign load_val = opc_reg ? DEC_INSTR.regv[CNT_W-1:0]
                            : DEC_INSTR.imm[CNT_W-1:0];

  // iteration
  // counter after this execution
  wire [CNT_W-1:0] cnt_dec;
  // zero reached after the decrement
  wire cnt_zero;
  // condition test on the flags of this execution
  wire cond_hit;
  // interrupt between iterations, only for interruptible loops
  wire int_brk;
  // one execution of the repeated instruction has finished
  wire iter;
  wire fin_count;
  wire fin_cond;
  wire fin_int;
  wire finish;

  // decrement first, then test; zero start wraps [RULE6] [RULE8]
  assign cnt_dec = cnt_q - CNT_W'(`RLC_CNT_ONE);
  assign cnt_zero = cnt_dec == CNT_W'(`RLC_CNT_ZERO); // [RULE6]

  rlc_cond_eval u_cond (
    .sel(sel_q),
    .flags(EXEC_FLAGS),
    .hit(cond_hit)
  );

  // an iteration is one finished execution while looping
  assign iter = (state_q == RLC_LOOP) & EXEC_DONE; // [RULE1]
  assign fin_count = iter & cnt_zero; // [RULE7]
  // flags of the same execution as the zero test [RULE18]
  assign fin_cond = iter & cond_q & cond_hit; // [RULE9]
  // uninterruptible loops ignore any take [RULE12] [RULE13]
  assign int_brk = (state_q == RLC_LOOP) & intr_q & INT_TAKEN;
  // loop is dropped, not resumed, after the interrupt [RULE14]
  assign fin_int = int_brk;
  assign finish = fin_count | fin_cond | fin_int;

  // bus decode
  // word index of the request
  wire [5:0] wb_word;
  wire wb_req;
  wire sel_cnt;
  wire sel_stat;
  wire sel_ctrl;
  // write lands on the edge that sees ack high
  wire wb_wr;
  wire wr_cnt;
  wire wr_ctrl;
  // byte-lane merged counter value
  wire [CNT_W-1:0] cnt_wval;
  // read views
  wire [31:0] stat_view;
  wire [31:0] cnt_view;
  wire [31:0] ctrl_view;

  // byte address in, only whole words are decoded
  assign wb_word = WB_ADR_I[7:`RLC_WORD_LO];
  assign wb_req = WB_CYC_I & WB_STB_I;
  // unmapped words match none of these and read as zero
  assign sel_cnt = wb_word == 6'(`RLC_OFS_CNT >> `RLC_WORD_LO);
  assign sel_stat = wb_word == 6'(`RLC_OFS_STAT >> `RLC_WORD_LO);
  assign sel_ctrl = wb_word == 6'(`RLC_OFS_CTRL >> `RLC_WORD_LO);
  assign wb_wr = wb_req & WB_WE_I & ack_q;
  assign wr_cnt = wb_wr & sel_cnt;
  assign wr_ctrl = wb_wr & sel_ctrl & WB_SEL_I[0];

  // software access to the counter [RULE17]
  // lane 1 is the high byte, lanes 2 and 3 have no bits here
  assign cnt_wval = {WB_SEL_I[1] ? WB_DAT_I[15:8] : cnt_q[15:8],
                     WB_SEL_I[0] ? WB_DAT_I[7:0] : cnt_q[7:0]};

  // status: live loop state and last exit cause
  assign stat_view = {26'h000_0000,
                      exit_q,
                      cond_q,
                      intr_q,
                      state_q == RLC_LOOP};
  assign cnt_view = 32'(cnt_q);
  assign ctrl_view = {31'h0000_0000, ctrl_en_q};

  // next state
  // loop sequencer
  always_comb begin
    state_d = state_q;
    intr_d = intr_q;
    cond_d = cond_q;
    sel_d = sel_q;
    exit_d = exit_q;
    case (state_q)
      RLC_IDLE: begin
        // a repeat arms the loop for the next instruction
        if (rep_go) begin
          state_d = RLC_LOOP;
          intr_d = var_int;
          cond_d = var_cond;
          sel_d = var_sel;
          exit_d = '0;
        end
      end
      RLC_LOOP: begin
        // any exit returns control to normal fetch [RULE7]
        if (finish) begin
          state_d = RLC_IDLE;
          exit_d.by_count = fin_count;
          exit_d.by_cond = fin_cond;
          exit_d.by_int = fin_int;
        end
      end
      default: begin
        state_d = RLC_IDLE;
      end
    endcase
  end

  // counter: load, decrement, or software write
  always_comb begin
    cnt_d = cnt_q;
    if (rep_go) begin
      cnt_d = load_val; // [RULE6]
    end else if (iter) begin
      // kept after an interrupt so software can reload [RULE15]
      cnt_d = cnt_dec; // [RULE6] [RULE8]
    end else if (wr_cnt) begin
      // hardware update wins over a same-cycle write
      cnt_d = cnt_wval; // [RULE17]
    end
  end

  // control register write
  always_comb begin
    ctrl_en_d = ctrl_en_q;
    if (wr_ctrl) begin
      ctrl_en_d = WB_DAT_I[`RLC_CTRL_EN_BIT];
    end
  end

  // read data captured in the cycle before ack
  always_comb begin
    rdat_d = 32'h0000_0000;
    if (sel_cnt) begin
      rdat_d = cnt_view;
    end else if (sel_stat) begin
      rdat_d = stat_view;
    end else if (sel_ctrl) begin
      rdat_d = ctrl_view;
    end
  end

  // registers
  // sequencer state
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      state_q <= RLC_IDLE;
      intr_q <= 1'b0;
      cond_q <= 1'b0;
      sel_q <= 4'h0;
      exit_q <= '0;
    end else begin
      state_q <= state_d;
      intr_q <= intr_d;
      cond_q <= cond_d;
      sel_q <= sel_d;
      // exit cause stays readable until the next load
      exit_q <= exit_d;
    end
  end

  // counter carries no reset, value is undefined [RULE17]
  always_ff @(posedge CLK_SYS) begin
    cnt_q <= cnt_d;
  end

  // control register
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      ctrl_en_q <= `RLC_CTRL_RST;
    end else begin
      ctrl_en_q <= ctrl_en_d;
    end
  end

  // bus answer: ack one cycle after the request, one cycle wide
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      ack_q <= 1'b0;
      rdat_q <= 32'h0000_0000;
    end else begin
      ack_q <= wb_req & ~ack_q;
      if (wb_req & ~ack_q) begin
        rdat_q <= rdat_d;
      end
    end
  end

  // pipeline steering outputs
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      is_rep_q <= 1'b0;
      loop_end_q <= 1'b0;
      inhibit_q <= 1'b0;
    end else begin
      // tells execute to skip the and result write
      is_rep_q <= rep_go; // [RULE3]
      loop_end_q <= (state_q == RLC_LOOP) & finish;
      // follows the next state, so it rises and falls with the loop
      inhibit_q <= (state_d == RLC_LOOP) & ~intr_d; // [RULE12]
    end
  end

  // outputs
  // the active flag is the loop state flop itself [RULE1]
  assign REPEAT_ACTIVE = state_q == RLC_LOOP;
  // inhibit only while an uninterruptible loop runs [RULE12]
  assign INT_INHIBIT = inhibit_q;
  assign IS_REPEAT = is_rep_q;
  assign LOOP_END = loop_end_q;
  // bus answer and read data straight from their flops
  assign WB_ACK_O = ack_q;
  assign WB_DAT_O = rdat_q;

endmodule

// ==== test/rlc_top_props.sv ====
`timescale 1ns/1ns
// loop steering and bus timing seen at the top ports
module rlc_top_props (
  input wire logic CLK_SYS,
  input wire logic ARST_N,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_ACK_O,
  input wire logic DEC_VALID,
  input wire logic EXEC_DONE,
  input wire logic INT_TAKEN,
  input wire logic IS_REPEAT,
  input wire logic REPEAT_ACTIVE,
  input wire logic INT_INHIBIT,
  input wire logic LOOP_END
);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!ARST_N);
  property p_ack;
    WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O;
  endproperty
  a_ack: assert property (p_ack) else $error("ack late");
  property p_ack_pulse;
    WB_ACK_O |=> !WB_ACK_O;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("ack held");
  property p_start;
    IS_REPEAT |-> REPEAT_ACTIVE && $past(DEC_VALID) && !$past(REPEAT_ACTIVE);
  endproperty
  a_start: assert property (p_start) else $error("bad start");
  property p_hold;
    REPEAT_ACTIVE && !EXEC_DONE && !INT_TAKEN |=> REPEAT_ACTIVE;
  endproperty
  a_hold: assert property (p_hold) else $error("loop dropped");
  property p_inhibit;
    INT_INHIBIT |-> REPEAT_ACTIVE;
  endproperty
  a_inhibit: assert property (p_inhibit)
    else $error("stray inhibit");
  property p_int_exit;
    INT_TAKEN && REPEAT_ACTIVE && !INT_INHIBIT |=> !REPEAT_ACTIVE && LOOP_END;
  endproperty
  a_int_exit: assert property (p_int_exit)
    else $error("no int exit");
  property p_end;
    LOOP_END |-> !REPEAT_ACTIVE && $past(REPEAT_ACTIVE);
  endproperty
  a_end: assert property (p_end) else $error("bad loop end");
  property p_fall;
    $fell(REPEAT_ACTIVE) |-> LOOP_END && $past(EXEC_DONE || INT_TAKEN);
  endproperty
  a_fall: assert property (p_fall)
    else $error("end without cause");
  // main scenarios reached
  c_start: cover property (IS_REPEAT);
  c_int: cover property (INT_TAKEN && REPEAT_ACTIVE);
  c_end: cover property (LOOP_END);
endmodule
bind rlc_top rlc_top_props u_props (.CLK_SYS(CLK_SYS), .ARST_N(ARST_N),
  .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_ACK_O(WB_ACK_O),
  .DEC_VALID(DEC_VALID), .EXEC_DONE(EXEC_DONE), .INT_TAKEN(INT_TAKEN),
  .IS_REPEAT(IS_REPEAT), .REPEAT_ACTIVE(REPEAT_ACTIVE),
  .INT_INHIBIT(INT_INHIBIT), .LOOP_END(LOOP_END));

// ==== test/rlc_pipe_model.sv ====
`timescale 1ns/1ns
// execute stage: finishes the repeated instruction every gap+1 cycles
module rlc_pipe_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic active,
  input wire logic [1:0] gap,
  output logic done
);
  logic [1:0] wait_q; // cycles since last finish
  // one non-branching instruction, re-run only while looping
  assign done = active && (wait_q == gap);
  // gap only changes while idle, so wait_q never passes it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      wait_q <= 2'h0;
    else if (!active || done)
      wait_q <= 2'h0;
    else
      wait_q <= wait_q + 2'h1;
  end
endmodule

// ==== test/tb_top.sv ====
`timescale 1ns/1ns
`include "rlc_defs.svh"
// random loops of every variant against a counting model of the block
module tb_top;
  import rlc_pkg::*;
  logic CLK_SYS, ARST_N, WB_CYC_I, WB_STB_I, WB_WE_I, WB_ACK_O;
  logic [7:0] WB_ADR_I, vv;
  logic [3:0] WB_SEL_I;
  logic [31:0] WB_DAT_I, WB_DAT_O, seed, q;
  logic DEC_VALID, EXEC_DONE, INT_TAKEN;
  logic IS_REPEAT, REPEAT_ACTIVE, INT_INHIBIT, LOOP_END;
  rlc_instr_t DEC_INSTR;
  rlc_flags_t EXEC_FLAGS;
  logic [1:0] gap; // model pace
  logic [15:0] cnt; // expected counter
  int err_total, num_checks, int_cd, i;
  rlc_top u_dut (.CLK_SYS(CLK_SYS), .ARST_N(ARST_N), .WB_CYC_I(WB_CYC_I),
    .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I),
    .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O),
    .WB_ACK_O(WB_ACK_O), .DEC_VALID(DEC_VALID), .DEC_INSTR(DEC_INSTR),
    .EXEC_DONE(EXEC_DONE), .EXEC_FLAGS(EXEC_FLAGS), .INT_TAKEN(INT_TAKEN),
    .IS_REPEAT(IS_REPEAT), .REPEAT_ACTIVE(REPEAT_ACTIVE),
    .INT_INHIBIT(INT_INHIBIT), .LOOP_END(LOOP_END));
  rlc_pipe_model u_pipe (.clk(CLK_SYS), .rst_n(ARST_N),
    .active(REPEAT_ACTIVE), .gap(gap), .done(EXEC_DONE));
  initial begin
    CLK_SYS = 1'h0;
    forever #25 CLK_SYS = ~CLK_SYS;
  end
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // exit test: upper half plain, lower half negated
  function automatic logic hit(input logic [3:0] s, input rlc_flags_t f);
    logic r;
    case (s[2:0])
      3'h0: r = f.st;
      3'h1: r = f.c & !f.z;
      3'h2: r = f.n | f.z;
      3'h3: r = f.c;
      3'h4: r = f.vt;
      3'h5: r = f.v;
      3'h6: r = f.n;
      default: r = f.z;
    endcase
    return s[3] ? r : !r;
  endfunction
  // fresh flags each cycle; interrupt taken only inside a live loop
  always @(posedge CLK_SYS) begin
    EXEC_FLAGS <= rlc_flags_t'(6'(xs()));
    INT_TAKEN <= (int_cd == 1) && REPEAT_ACTIVE;
    if (int_cd > 0 && REPEAT_ACTIVE) int_cd <= int_cd - 1;
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("Error %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task conclude;
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // one classic cycle; q takes read data at the ack edge
  task wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge CLK_SYS);
    WB_CYC_I <= 1'h1;
    WB_STB_I <= 1'h1;
    WB_WE_I <= we;
    WB_SEL_I <= 4'hf;
    WB_ADR_I <= a;
    WB_DAT_I <= d;
    for (k = 0; k < 9 && WB_ACK_O !== 1'h1; k++) @(posedge CLK_SYS);
    q = WB_DAT_O;
    if (k == 9) begin
      err_total++;
      conclude;
    end
    WB_CYC_I <= 1'h0;
    WB_STB_I <= 1'h0;
    @(negedge CLK_SYS);
  endtask
  task dec(input logic [7:0] op, v, d, input logic [15:0] n);
    @(posedge CLK_SYS);
    DEC_VALID <= 1'h1;
    // the unused count source is inverted so a wrong pick shows
    DEC_INSTR <= '{op, op == `RLC_OPC_REG ? ~n : n,
                   op == `RLC_OPC_REG ? n : ~n, v, d};
    @(posedge CLK_SYS);
    DEC_VALID <= 1'h0;
    @(negedge CLK_SYS);
  endtask
  // start a loop, follow every iteration, then read back the counter
  task run(input logic [7:0] op, v, input logic [15:0] n, input int ia,
           input logic [1:0] g);
    logic fin;
    int k;
    logic [2:0] why;
    gap = g;
    dec(op, v, `RLC_DEST_CNT, n);
    int_cd = ia;
    cnt = n;
    fin = 1'h0;
    chk(IS_REPEAT, 1);
    chk(INT_INHIBIT, !v[5]);
    for (k = 0; k < 70000 && !fin; k++) begin
      chk(REPEAT_ACTIVE, 1);
      if (EXEC_DONE) cnt--;
      // exit causes: taken interrupt, condition hit, count spent
      why = {INT_TAKEN && v[5], EXEC_DONE && v[4] && hit(v[3:0], EXEC_FLAGS),
             EXEC_DONE && cnt == 0};
      fin = |why;
      @(negedge CLK_SYS);
    end
    if (!fin) begin
      err_total++;
      conclude;
    end
    chk(REPEAT_ACTIVE, 0);
    chk(LOOP_END, 1);
    wb(1'h0, `RLC_OFS_CNT, 0);
    chk(q, {16'h0000, cnt});
    wb(1'h0, `RLC_OFS_STAT, 0);
    chk(q, {26'h000_0000, why, v[4], v[5], 1'h0});
  endtask
  initial begin
    seed = 32'h18ca_09cf;
    {ARST_N, WB_CYC_I, WB_STB_I, WB_WE_I, DEC_VALID, INT_TAKEN} = 6'h00;
    {WB_ADR_I, WB_DAT_I, DEC_INSTR, EXEC_FLAGS} = '0;
    WB_SEL_I = 4'hf;
    {int_cd, gap, err_total, num_checks} = '0;
    repeat (6) @(posedge CLK_SYS);
    ARST_N <= 1'h1;
    @(negedge CLK_SYS);
    cnt = 16'(xs());
    wb(1'h1, `RLC_OFS_CNT, {16'hffff, cnt});
    wb(1'h0, `RLC_OFS_CNT, 0);
    chk(q, {16'h0000, cnt});
    wb(1'h0, 8'h40, 0);
    chk(q, 0);
    $display("test registers done");
    // decode bytes outside the four variants, and the plain and form
    foreach (vv[b]) begin
      dec(`RLC_OPC_IMM, b == 4 ? 8'h50 : 8'h01 << b | 8'h01,
          `RLC_DEST_CNT, 16'h0003);
      chk(IS_REPEAT, 0);
    end
    dec(`RLC_OPC_IMM, 8'h00, 8'h20, 16'h0003);
    chk(REPEAT_ACTIVE, 0);
    // decoding switched off: a valid repeat must be left alone
    wb(1'h1, `RLC_OFS_CTRL, 0);
    dec(`RLC_OPC_IMM, 8'h20, `RLC_DEST_CNT, 16'h0003);
    chk(REPEAT_ACTIVE, 0);
    wb(1'h1, `RLC_OFS_CTRL, 1);
    wb(1'h0, `RLC_OFS_CTRL, 0);
    chk(q, 1);
    $display("test refused done");
    for (i = 0; i < 34; i++) begin
      vv = i < 2 ? 8'(i * 32) : 8'h10 + 8'(i - 2) + (i > 17 ? 8'h10 : 8'h00);
      run(`RLC_OPC_IMM, vv, 16'(1 + xs() % 8),
          vv[5] ? 1 + xs() % 6 : 0, 2'(xs()));
      // interruptible loop left with count remaining: reload the rest from the counter via a register
      if (vv[5] && cnt != 0)
        run(`RLC_OPC_REG, vv, cnt, 0, 2'h1);
    end
    $display("test variants done");
    run(`RLC_OPC_IMM, 8'h00, 16'h0000, 0, 2'h0);
    $display("test wrap done");
    conclude;
  end
endmodule
